// ### include/mspwm_consts.svh
// timing counts, widths, source codes and reset values for the pwm generator
`ifndef MSPWM_CONSTS_SVH
`define MSPWM_CONSTS_SVH
`define MSPWM_LANES          8
`define MSPWM_CHANNELS       4
`define MSPWM_DT_WIDTH       16
`define MSPWM_TICK_NS        4
`define MSPWM_DT_MIN_NS      4
`define MSPWM_DT_MAX_NS      262000
`define MSPWM_DT_MAX_CYC     (`MSPWM_DT_MAX_NS / `MSPWM_TICK_NS)
`define MSPWM_CNT_WIDTH      16
`define MSPWM_PP_ANGLES      16
`define MSPWM_PP_PHASES      3
`define MSPWM_PP_ANGLE_MAX   16'hEA60
`define MSPWM_SRC_CARRIER    2'h0
`define MSPWM_SRC_DIRECT     2'h1
`define MSPWM_SRC_PATTERN    2'h2
`define MSPWM_SRC_USER       2'h3
`define MSPWM_RST_LANES      8'h00
`endif

// ### include/mspwm_pkg.sv
// types shared by the pwm generator files
package mspwm_pkg;
  typedef enum logic [1:0] {
    MSPWM_CARRIER_SAW_UP,
    MSPWM_CARRIER_SAW_DOWN,
    MSPWM_CARRIER_TRIANGLE,
    MSPWM_CARRIER_TRIANGLE_INV
  } mspwm_carrier_type;
  typedef enum logic [1:0] {
    MSPWM_MODE_HILO,
    MSPWM_MODE_SW_AUTH,
    MSPWM_MODE_INDEPENDENT,
    MSPWM_MODE_RSVD
  } mspwm_chan_mode_type;
  typedef enum logic [1:0] {
    MSPWM_SRC_SEL_CARRIER,
    MSPWM_SRC_SEL_DIRECT,
    MSPWM_SRC_SEL_PATTERN,
    MSPWM_SRC_SEL_USER
  } mspwm_src_type;
endpackage : mspwm_pkg

// ### src/mspwm_dead_time.sv
// rising-edge delay stage for one lane
`timescale 1ns/1ps
module mspwm_dead_time #(
  parameter int DT_WIDTH = 16
) (
  input  wire logic                ref_clk,    // 250 mhz logic clock
  input  wire logic                rst,        // sync reset
  input  wire logic [DT_WIDTH-1:0] deadTime,   // delay in ticks
  input  wire logic                bypass,     // pass input straight
  input  wire logic                sigIn,      // raw lane level
  output logic                     sigOut      // delayed lane level
);
  import mspwm_pkg::*;
  typedef enum logic [1:0] {DT_LOW, DT_WAIT, DT_HIGH} mspwm_dt_state_type;
  mspwm_dt_state_type stateReg;
  logic [DT_WIDTH-1:0] countReg;

  initial begin
    if (DT_WIDTH < 2) $error("dead time width too small");
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateReg <= DT_LOW;
      countReg <= '0;
      sigOut   <= 1'b0;
    end else if (bypass) begin
      stateReg <= DT_LOW;
      countReg <= '0;
      sigOut   <= sigIn;
    end else begin
      unique case (stateReg)
        DT_LOW: begin
          sigOut <= 1'b0;
          if (sigIn) begin
            stateReg <= DT_WAIT;                        // RULE_04
            countReg <= (deadTime == '0) ? DT_WIDTH'(1) : deadTime;
          end
        end
        DT_WAIT: begin
          if (!sigIn) begin
            stateReg <= DT_LOW;                         // RULE_05
          end else if (countReg <= DT_WIDTH'(1)) begin
            stateReg <= DT_HIGH;
            sigOut   <= 1'b1;
          end else begin
            countReg <= countReg - DT_WIDTH'(1);        // RULE_19
          end
        end
        DT_HIGH: begin
          if (!sigIn) begin
            stateReg <= DT_LOW;                         // RULE_04
            sigOut   <= 1'b0;
          end
        end
        default: begin
          stateReg <= DT_LOW;
          sigOut   <= 1'b0;
        end
      endcase
    end
  end
endmodule : mspwm_dead_time

// ### src/mspwm_top.sv
// eight-lane multi-source pwm generator with dead time and fault blocking
// Operation
// RULE_01: each lane direct or through dead time
// RULE_02: eight lanes grouped into four channels
// RULE_03: odd lane low side, even high side
// RULE_04: rising edges delayed, 4 ns steps
// RULE_05: pulses shorter than dead time suppressed
// RULE_06: dead-time stage can be bypassed
// RULE_07: any source routable to any lane
// RULE_08: four carrier modulators, complementary, 16-bit
// RULE_09: triangle updates once or twice per period
// RULE_10: space vector links adjacent modulators
// RULE_11: direct source drives written lane states
// RULE_12: direct lanes also get dead time, blocking
// RULE_13: pattern counter fixed period, external tick
// RULE_14: three-phase angle tables with direction bits
// RULE_15: user logic signals feed lanes via dead time
// RULE_16: fault blocks all output lanes
// RULE_17: independent mode: no channel, no dead time
// RULE_18: switching plus authorisation lane pairing
// RULE_19: counters on 4 ns clock, sync clear
`timescale 1ns/1ps
`include "mspwm_consts.svh"
module mspwm_top #(
  parameter int LANES    = `MSPWM_LANES,
  parameter int CHANNELS = `MSPWM_CHANNELS,
  parameter int CW       = `MSPWM_CNT_WIDTH,
  parameter int DTW      = `MSPWM_DT_WIDTH,
  parameter int ANGLES   = `MSPWM_PP_ANGLES
) (
  input  wire logic                                  ref_clk,         // logic clock
  input  wire logic                                  rst,             // sync reset, high
  input  wire logic [CHANNELS-1:0][CW-1:0]           carrierPeriod,   // ticks per period
  input  wire logic [CHANNELS-1:0][CW-1:0]           carrierDuty,     // compare value
  input  wire logic [CHANNELS-1:0][CW-1:0]           carrierPhase,    // compare offset added to count
  input  wire mspwm_pkg::mspwm_carrier_type [CHANNELS-1:0] carrierType, // carrier shape
  input  wire logic [CHANNELS-1:0]                   doubleUpdate,    // reload twice a period, triangle carriers only
  input  wire logic [CHANNELS/2-1:0]                 spaceVectorMode, // pair modulators
  input  wire logic [LANES-1:0]                      directState,     // cpu-written levels
  input  wire logic                                  patternTick,     // variable-rate step
  input  wire logic [`MSPWM_PP_PHASES-1:0][ANGLES-1:0][CW-1:0] patternAngle, // angle_table
  input  wire logic [`MSPWM_PP_PHASES-1:0][ANGLES-1:0] patternDir,    // up/down per angle
  input  wire logic [LANES-1:0]                      userLogicLanes,  // user area signals
  input  wire mspwm_pkg::mspwm_src_type [CHANNELS-1:0] channelSource, // per-channel source
  input  wire mspwm_pkg::mspwm_chan_mode_type [CHANNELS-1:0] channelMode, // lane pairing
  input  wire logic [LANES-1:0]                      deadTimeEnable,  // per-lane dt use
  input  wire logic [CHANNELS-1:0][DTW-1:0]          deadTime,        // dt in ticks
  input  wire logic                                  faultIn_n,       // fault pin, low = fault
  output logic [LANES-1:0]                           gateOut,         // optical lanes
  output logic                                       faultActive,     // blocking in force
  output logic [CHANNELS-1:0][CW-1:0]                carrierCount     // modulator counters
);
  import mspwm_pkg::*;

  initial begin
    if (LANES != 2 * CHANNELS) $error("lanes must be twice channels");
    if (CW < 16 || DTW < 16) $error("counter widths below 16 bits");
    if (ANGLES < 1) $error("angle table empty");
  end

  // fault pin synchroniser
  logic faultSync1Reg;
  logic faultSync2Reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      faultSync1Reg <= 1'b1;
      faultSync2Reg <= 1'b1;
    end else begin
      faultSync1Reg <= faultIn_n;
      faultSync2Reg <= faultSync1Reg;
    end
  end

  // carrier modulators
  logic [CHANNELS-1:0]         dirDownReg;
  logic [CHANNELS-1:0][CW-1:0] dutyReg;
  logic [CHANNELS-1:0][CW-1:0] cntReg;
  logic [CHANNELS-1:0]         carrierOutReg;

  function automatic logic atReload(input logic [CW-1:0] cnt, input logic [CW-1:0] per,
                                    input logic down, input mspwm_carrier_type ct,
                                    input logic dbl);
    logic top;
    logic bottom;
    top    = (cnt >= per - CW'(1));
    bottom = (cnt == '0);
    if (ct == MSPWM_CARRIER_TRIANGLE || ct == MSPWM_CARRIER_TRIANGLE_INV) begin
      return (bottom && down) || (dbl && top && !down);          // RULE_09
    end
    return (ct == MSPWM_CARRIER_SAW_UP) ? top : bottom;
  endfunction : atReload

  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (rst) begin
        cntReg[c]     <= '0;                                     // RULE_19
        dirDownReg[c] <= 1'b0;
        dutyReg[c]    <= '0;
      end else begin
        if (atReload(cntReg[c], carrierPeriod[c], dirDownReg[c], carrierType[c],
                     doubleUpdate[c])) begin
          dutyReg[c] <= carrierDuty[c];
        end
        unique case (carrierType[c])
          MSPWM_CARRIER_SAW_UP: begin
            cntReg[c] <= (cntReg[c] >= carrierPeriod[c] - CW'(1)) ? '0
                         : cntReg[c] + CW'(1);                   // RULE_08
          end
          MSPWM_CARRIER_SAW_DOWN: begin
            cntReg[c] <= (cntReg[c] == '0) ? carrierPeriod[c] - CW'(1)
                         : cntReg[c] - CW'(1);
          end
          MSPWM_CARRIER_TRIANGLE, MSPWM_CARRIER_TRIANGLE_INV: begin
            if (!dirDownReg[c]) begin
              if (cntReg[c] >= carrierPeriod[c] - CW'(1)) begin
                dirDownReg[c] <= 1'b1;
                cntReg[c]     <= cntReg[c] - CW'(1);
              end else begin
                cntReg[c] <= cntReg[c] + CW'(1);
              end
            end else if (cntReg[c] == '0) begin
              dirDownReg[c] <= 1'b0;
              cntReg[c]     <= CW'(1);
            end else begin
              cntReg[c] <= cntReg[c] - CW'(1);
            end
          end
        endcase
      end
    end
  end

  // phase offset applied as compare shift; space vector reuses partner counter
  always_ff @(posedge ref_clk) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (rst) begin
        carrierOutReg[c] <= 1'b0;
        carrierCount[c]  <= '0;
      end else begin
        carrierCount[c] <= cntReg[c];
        if (spaceVectorMode[c/2] && c[0]) begin
          carrierOutReg[c] <= (cntReg[(c/2)*2] + carrierPhase[c]) < dutyReg[c]; // RULE_10
        end else if (carrierType[c] == MSPWM_CARRIER_TRIANGLE_INV) begin
          carrierOutReg[c] <= (cntReg[c] + carrierPhase[c]) >= dutyReg[c];
        end else begin
          carrierOutReg[c] <= (cntReg[c] + carrierPhase[c]) < dutyReg[c];   // RULE_08
        end
      end
    end
  end

  // programmed pattern: fixed period counter stepped by external tick
  logic [CW-1:0]                         patCntReg;
  logic [`MSPWM_PP_PHASES-1:0]           patOutReg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      patCntReg <= '0;
      patOutReg <= '0;
    end else if (patternTick) begin
      patCntReg <= (patCntReg >= CW'(`MSPWM_PP_ANGLE_MAX)) ? '0
                   : patCntReg + CW'(1);                         // RULE_13
      for (int p = 0; p < `MSPWM_PP_PHASES; p++) begin
        for (int a = 0; a < ANGLES; a++) begin
          if (patternAngle[p][a] == patCntReg) begin
            patOutReg[p] <= patternDir[p][a];                    // RULE_14
          end
        end
      end
    end
  end

  // source matrix: channel pairs low (odd) / high (even) lanes
  logic [LANES-1:0] srcLanes;
  always_comb begin
    srcLanes = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      unique case (channelSource[c])                             // RULE_07
        MSPWM_SRC_SEL_CARRIER: begin
          srcLanes[2*c]   = carrierOutReg[c];                    // RULE_03
          srcLanes[2*c+1] = ~carrierOutReg[c];
        end
        MSPWM_SRC_SEL_DIRECT: begin
          srcLanes[2*c]   = directState[2*c];                    // RULE_11
          srcLanes[2*c+1] = directState[2*c+1];
        end
        MSPWM_SRC_SEL_PATTERN: begin
          srcLanes[2*c]   = patOutReg[c % `MSPWM_PP_PHASES];     // RULE_14
          srcLanes[2*c+1] = ~patOutReg[c % `MSPWM_PP_PHASES];
        end
        MSPWM_SRC_SEL_USER: begin
          srcLanes[2*c]   = userLogicLanes[2*c];                 // RULE_15
          srcLanes[2*c+1] = userLogicLanes[2*c+1];
        end
      endcase
      unique case (channelMode[c])
        MSPWM_MODE_SW_AUTH: begin
          srcLanes[2*c+1] = (channelSource[c] == MSPWM_SRC_SEL_DIRECT)
                            ? directState[2*c+1] : 1'b1;         // RULE_18
        end
        MSPWM_MODE_INDEPENDENT: begin
          if (channelSource[c] == MSPWM_SRC_SEL_CARRIER) begin
            srcLanes[2*c+1] = carrierOutReg[c];                  // RULE_17
          end
        end
        default: begin
        end
      endcase
    end
  end

  // dead-time stage per lane
  logic [LANES-1:0] dtLanes;
  for (genvar l = 0; l < LANES; l++) begin : gLane
    mspwm_dead_time #(
      .DT_WIDTH (DTW)
    ) uDeadTime (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .deadTime (deadTime[l/2]),
      .bypass   (~deadTimeEnable[l]
                 || channelMode[l/2] != MSPWM_MODE_HILO),        // RULE_06
      .sigIn    (srcLanes[l]),
      .sigOut   (dtLanes[l])                                     // RULE_01
    );
  end

  // fault blocking; all sources pass here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gateOut     <= `MSPWM_RST_LANES;
      faultActive <= 1'b0;
    end else begin
      faultActive <= ~faultSync2Reg;
      gateOut     <= faultSync2Reg ? dtLanes : '0;               // RULE_16
    end
  end
  // RULE_02 RULE_12: lanes 2c/2c+1 form channel c for every source
endmodule : mspwm_top

// ### dv/mspwm_gate_sink.sv
// optical gate-drive receiver model counting lit cycles per lane
`timescale 1ns/1ps
module mspwm_gate_sink (
  input  wire logic             ref_clk,  // logic clock
  input  wire logic             clr,      // clear the counts
  input  wire logic [7:0]       lanes,    // optical lanes
  output logic      [7:0][15:0] litCount  // lit cycles per lane
);
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 8; i++) begin
      litCount[i] <= clr ? 16'h0000 : litCount[i] + 16'(lanes[i]);
    end
  end
endmodule : mspwm_gate_sink

// ### dv/mspwm_top_assertions.sv
// port-level checks of the pwm generator
`timescale 1ns/1ps
module mspwm_checker #(
  parameter int LANES = 8, parameter int CHANNELS = 4, parameter int CW = 16, parameter int DTW = 16
) (
  input wire logic                                         ref_clk,       // clock
  input wire logic                                         rst,           // sync reset
  input wire logic [CHANNELS-1:0][CW-1:0]                  carrierPeriod, // periods
  input wire mspwm_pkg::mspwm_carrier_type [CHANNELS-1:0]  carrierType,   // shapes
  input wire logic [LANES-1:0]                             directState,   // cpu levels
  input wire mspwm_pkg::mspwm_src_type [CHANNELS-1:0]      channelSource, // sources
  input wire mspwm_pkg::mspwm_chan_mode_type [CHANNELS-1:0] channelMode,  // pairing
  input wire logic [LANES-1:0]                             deadTimeEnable, // dt use
  input wire logic [CHANNELS-1:0][DTW-1:0]                 deadTime,      // dt ticks
  input wire logic                                         faultIn_n,     // fault pin
  input wire logic [LANES-1:0]                             gateOut,       // lanes
  input wire logic                                         faultActive,   // blocking
  input wire logic [CHANNELS-1:0][CW-1:0]                  carrierCount   // counters
);
  import mspwm_pkg::*;
  logic [DTW:0] hiCount;
  logic         live;
  logic         dirOk;
  logic         dtOk;
  assign live = !rst && faultIn_n && !faultActive;
  assign dirOk = live && channelSource[0] == MSPWM_SRC_SEL_DIRECT
                 && channelMode[0] == MSPWM_MODE_INDEPENDENT && deadTimeEnable[1:0] == 2'b00;
  assign dtOk = live && channelSource[0] == MSPWM_SRC_SEL_DIRECT
                && channelMode[0] == MSPWM_MODE_HILO && deadTimeEnable[1:0] == 2'b11;
  // length of the current high run of directState[0], saturating
  always_ff @(posedge ref_clk) begin
    if (rst || !directState[0]) hiCount <= '0;
    else if (!hiCount[DTW]) hiCount <= hiCount + 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_clears: assert property (disable iff (1'b0) rst |=>
    gateOut == '0 && !faultActive && carrierCount == '0) else $error("outputs not cleared");
  a_fault_blocks: assert property (!faultIn_n [*3] |=> gateOut == '0)
    else $error("lanes not blocked on fault");
  a_fault_flag: assert property (!faultIn_n [*3] |=> faultActive)
    else $error("fault flag missing");
  a_direct_pass: assert property (dirOk [*4] |->
    gateOut[1:0] == $past(directState[1:0], 2)) else $error("direct lane level wrong");
  a_fall_passes: assert property (dtOk [*4] ##0 $fell(directState[0]) |->
    ##[1:3] !gateOut[0]) else $error("falling edge delayed");
  a_short_pulse: assert property (dtOk [*4] ##0 $rose(gateOut[0]) |->
    $past(hiCount, 2) + 1'b1 >= deadTime[0]) else $error("pulse shorter than dead time");
  a_auth_enable: assert property ((live && channelMode[1] == MSPWM_MODE_SW_AUTH
    && channelSource[1] == MSPWM_SRC_SEL_CARRIER) [*4] |-> gateOut[3]) else $error("no auth");
  a_count_bound: assert property ($stable(carrierPeriod[0]) [*3] |->
    carrierCount[0] <= carrierPeriod[0]) else $error("counter beyond period");
  a_count_moves: assert property ((live && carrierType[0] == MSPWM_CARRIER_SAW_UP
    && carrierPeriod[0] > 1) [*4] |-> carrierCount[0] != $past(carrierCount[0]))
    else $error("counter stuck");
endmodule : mspwm_checker
bind mspwm_top mspwm_checker #(.LANES(LANES), .CHANNELS(CHANNELS), .CW(CW), .DTW(DTW))
  mspwm_checker_i (.ref_clk(ref_clk), .rst(rst), .carrierPeriod(carrierPeriod),
    .carrierType(carrierType), .directState(directState), .channelSource(channelSource),
    .channelMode(channelMode), .deadTimeEnable(deadTimeEnable), .deadTime(deadTime),
    .faultIn_n(faultIn_n), .gateOut(gateOut), .faultActive(faultActive),
    .carrierCount(carrierCount));

// ### dv/mspwm_tb.sv
// self-checking bench for the pwm generator
`timescale 1ns/1ps
module mspwm_tb;
  import mspwm_pkg::*;
  logic ref_clk, faultActive, patternTick = 0, rst = 1, faultIn_n = 1, clr = 1;
  logic [3:0][15:0] carrierPeriod = {4{16'h000a}}, carrierDuty = {4{16'h0005}};
  logic [3:0][15:0] carrierPhase = '0, deadTime = {4{16'h0004}}, carrierCount;
  mspwm_carrier_type [3:0] carrierType = '{default: MSPWM_CARRIER_SAW_UP};
  logic [3:0] doubleUpdate = '0;
  logic [1:0] spaceVectorMode = '0;
  logic [7:0] directState = '0, userLogicLanes = '0, deadTimeEnable = '0, gateOut, x;
  logic [2:0][15:0][15:0] patternAngle = '0;
  logic [2:0][15:0] patternDir = '0;
  mspwm_src_type [3:0] channelSource = '{default: MSPWM_SRC_SEL_DIRECT};
  mspwm_chan_mode_type [3:0] channelMode = '{default: MSPWM_MODE_INDEPENDENT};
  logic [7:0][15:0] litCount;
  logic [7:0] expQ[$];
  int fail_count = 0;
  int num_checks = 0;
  mspwm_top mspwm_top_i (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .carrierPeriod   (carrierPeriod),
    .carrierDuty     (carrierDuty),
    .carrierPhase    (carrierPhase),
    .carrierType     (carrierType),
    .doubleUpdate    (doubleUpdate),
    .spaceVectorMode (spaceVectorMode),
    .directState     (directState),
    .patternTick     (patternTick),
    .patternAngle    (patternAngle),
    .patternDir      (patternDir),
    .userLogicLanes  (userLogicLanes),
    .channelSource   (channelSource),
    .channelMode     (channelMode),
    .deadTimeEnable  (deadTimeEnable),
    .deadTime        (deadTime),
    .faultIn_n       (faultIn_n),
    .gateOut         (gateOut),
    .faultActive     (faultActive),
    .carrierCount    (carrierCount)
  );
  mspwm_gate_sink mspwm_gate_sink_i (.ref_clk, .clr, .lanes(gateOut), .litCount);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #30000;
    fail_count++;
    finish_test();
  end
  // oldest note against the lanes, two edges behind the driver
  always @(posedge ref_clk) begin
    #2;
    if (expQ.size() >= 2) check({8'h00, gateOut}, {8'h00, expQ.pop_front()});
  end
  initial begin
    int n;
    void'($urandom(38));
    patternAngle = {24{$urandom}};
    patternDir = {16'($urandom), $urandom};
    cyc(16);
    check({7'h00, faultActive, gateOut}, 16'h0000);
    check(carrierCount[0], 16'h0000);
    rst = 0;
    $display("reset test done");
    for (int s = 1; s <= 3; s += 2) begin
      channelSource = '{default: mspwm_src_type'(s)};
      deadTimeEnable = (s == 3) ? 8'hff : 8'h00;
      repeat (40) begin
        cyc(1);
        x = 8'($urandom);
        if (s == 1) directState = x;
        else userLogicLanes = x;
        expQ.push_back(x);
      end
      cyc(3);
      expQ.delete();
      $display("source test %0d done", s);
    end
    channelSource = '{default: MSPWM_SRC_SEL_DIRECT};
    channelMode[0] = MSPWM_MODE_HILO;
    deadTimeEnable = 8'h03;
    deadTime[0] = 16'h0006;
    directState = 8'h00;
    cyc(10);
    clr = 0;
    directState = 8'h01;
    cyc(4);
    directState = 8'h00;
    cyc(12);
    check(litCount[0], 16'h0000);
    directState = 8'h01;
    for (n = 0; n < 20 && gateOut[0] !== 1'b1; n++) cyc(1);
    check(16'(n >= 6 && n <= 10), 16'h0001);
    cyc(10);
    directState = 8'h00;
    for (n = 0; n < 20 && gateOut[0] !== 1'b0; n++) cyc(1);
    check(16'(n >= 1 && n <= 3), 16'h0001);
    deadTimeEnable = 8'h00;
    directState = 8'h01;
    cyc(2);
    check({8'h00, gateOut}, 16'h0001);
    $display("dead time test done");
    channelSource = '{MSPWM_SRC_SEL_PATTERN, MSPWM_SRC_SEL_PATTERN,
                      MSPWM_SRC_SEL_CARRIER, MSPWM_SRC_SEL_CARRIER};
    channelMode = '{MSPWM_MODE_INDEPENDENT, MSPWM_MODE_INDEPENDENT,
                    MSPWM_MODE_SW_AUTH, MSPWM_MODE_HILO};
    for (int k = 0; k < 4; k++) begin
      carrierType = '{default: mspwm_carrier_type'(k)};
      doubleUpdate = 4'($urandom);
      spaceVectorMode = 2'($urandom);
      clr = 1;
      cyc(40);
      clr = 0;
      repeat (100) begin
        cyc(1);
        patternTick = 1'($urandom);
      end
      check(litCount[0] + litCount[1], 16'h0064);
      check(16'(litCount[0] inside {[1:99]}), 16'h0001);
      check(litCount[3], 16'h0064);
    end
    $display("carrier test done");
    faultIn_n = 0;
    cyc(4);
    check({7'h00, faultActive, gateOut}, 16'h0100);
    faultIn_n = 1;
    cyc(10);
    check({14'h0000, faultActive, gateOut[3]}, 16'h0001);
    $display("fault test done");
    // phase 2 table: rise at count 3, fall at count 7, rest out of reach
    patternAngle[2] = {16{16'hea60}};
    patternAngle[2][0] = 16'h0003;
    patternAngle[2][1] = 16'h0007;
    patternDir[2] = 16'h0001;
    rst = 1;
    cyc(2);
    check({7'h00, faultActive, gateOut}, 16'h0000);
    check(carrierCount[0], 16'h0000);
    rst = 0;
    patternTick = 1;
    cyc(4);
    patternTick = 0;
    cyc(3);
    check({14'h0000, gateOut[5:4]}, 16'h0001);
    patternTick = 1;
    cyc(4);
    patternTick = 0;
    cyc(3);
    check({14'h0000, gateOut[5:4]}, 16'h0002);
    $display("pattern test done");
    finish_test();
  end
endmodule : mspwm_tb
